// ### bench/bjc_jump_cache_sva.sv
// Assertions on the jump cache ports
`timescale 1ns/1ps
`default_nettype none
module bjc_jump_cache_sva
  import bjc_pkg::*;
(
  // Watched ports
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input var  bjc_jump_s   i_jump,
  input wire logic        i_irq_taken,
  input var  bjc_fetch_s  o_fetch,
  input wire logic        o_word_valid,
  input wire logic        o_from_cache,
  input wire logic        o_hit
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_hit_cause: assert property (o_hit |-> $past(i_jump.taken) &&
    $past(i_jump.cls) inside {BJC_CLS_REL, BJC_CLS_ABS, BJC_CLS_BIT}) else $error("hit from wrong class");
  a_hit_words: assert property (o_hit |=> (o_word_valid && o_from_cache && !o_fetch.req)
    ##1 (o_word_valid && o_from_cache)) else $error("cached pair missing");
  a_hit_single: assert property (o_hit |=> !o_hit ##1 !o_hit) else $error("hit repeated");
  a_hit_resume: assert property (o_hit |-> ##2 (o_fetch.req &&
    o_fetch.addr == $past(i_jump.target, 3) + HIT_RESUME)) else $error("wrong resume address");
  a_kill_hit: assert property (i_irq_taken ##1 i_jump.taken |=> !o_hit) else $error("hit after irq");
  a_miss_fetch: assert property ($rose(o_fetch.req) && $past(i_jump.taken) |->
    o_fetch.addr == $past(i_jump.target)) else $error("miss fetch address");
  a_cache_flag: assert property (o_from_cache |-> o_word_valid) else $error("stray cache flag");
endmodule
`default_nettype wire

// ### bench/bjc_mem_model.sv
// Program memory model answering fetches after a set delay
`timescale 1ns/1ps
`default_nettype none
module bjc_mem_model
  import bjc_pkg::*;
(
  // Clock and delay
  input  wire logic       i_clk,
  input  wire logic [3:0] i_dly,
  // Fetch and return
  input  var  bjc_fetch_s i_fetch,
  output logic            o_valid,
  output logic [15:0]     o_data
);
  logic        pend;
  logic [3:0]  cnt;
  logic [15:0] addr;
  initial
  begin
    pend = 1'b0;
    o_valid = 1'b0;
    o_data = 16'h0000;
  end
  // Data toggles when not valid, so a stale read shows
  always @(posedge i_clk)
  begin
    o_valid <= 1'b0;
    o_data <= ~o_data;
    if (i_fetch.req)
    begin
      pend <= 1'b1;
      addr <= i_fetch.addr;
      cnt <= i_dly;
    end
    else if (pend && cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else if (pend)
    begin
      pend <= 1'b0;
      o_valid <= 1'b1;
      o_data <= addr ^ 16'h5a5a;
    end
  end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Testbench for the jump cache
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bjc_pkg::*;
  logic        i_clk = 1'b0;
  logic        rst = 1'b1;
  bjc_jump_s   jmp = '0;
  logic        irq = 1'b0;
  logic        evt = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic        seq = 1'b0;
  logic        mv, wv, fc, hit;
  logic [15:0] md, word;
  bjc_fetch_s  fch;
  int          n_errors = 0;
  int          check_count = 0;
  always #25 i_clk = ~i_clk;
  bjc_jump_cache u_dut (.i_clk(i_clk), .i_sys_rst(rst), .i_jump(jmp), .i_irq_taken(irq), .i_evt_xfer(evt),
    .i_seq_req(seq), .o_fetch(fch), .i_mem_valid(mv), .i_mem_data(md), .o_word_valid(wv), .o_word(word),
    .o_from_cache(fc), .o_hit(hit));
  bjc_mem_model u_mem (.i_clk(i_clk), .i_dly(dly), .i_fetch(fch), .o_valid(mv), .o_data(md));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Mode 0 expects a fill, 1 a hit, 2 no hit
  task automatic run(input bjc_cls_e c, input logic [15:0] pc, input logic [15:0] a, input logic ev, input int m);
    int k;
    k = 0;
    @(posedge i_clk) jmp <= '{1'b1, c, pc, a};
    irq <= 1'b0;
    @(posedge i_clk) jmp <= '0;
    evt <= ev;
    @(negedge i_clk);
    chk(16'(hit), 16'(m == 1));
    if (m == 0)
      chk(fch.addr, a);
    @(posedge i_clk) evt <= 1'b0;
    for (int i = 0; i < 40 && m == 0 && k < 2; i++)
    begin
      @(negedge i_clk);
      if (wv === 1'b1)
      begin
        chk(word, (a + 16'(2 * k)) ^ 16'h5a5a);
        k++;
      end
    end
    if (m == 0 && k < 2)
    begin
      n_errors++;
      $display("mismatch at %0t: fill words missing", $time);
      end_sim();
    end
    if (m == 1)
    begin
      @(negedge i_clk) chk(word, a ^ 16'h5a5a);
      @(negedge i_clk) chk(word, (a + WORD_STEP) ^ 16'h5a5a);
      chk(16'(fc), 16'h1);
      chk(fch.addr, a + HIT_RESUME);
    end
    repeat (12) @(posedge i_clk);
  endtask
  // Miss fills the entry, the repeat hits
  task automatic sc_fill_hit;
    run(BJC_CLS_REL, 16'h0140, 16'h0100, 0, 0);
    run(BJC_CLS_REL, 16'h0140, 16'h0100, 0, 1);
  endtask
  // Slow memory; relative jump as target of a jump, transfer after it; fetch runs on past A+4
  task automatic sc_rel_target;
    dly <= 4'h3;
    run(BJC_CLS_ABS, 16'h0220, 16'h0240, 0, 0);
    run(BJC_CLS_REL, 16'h0240, 16'h0200, 1, 0);
    run(BJC_CLS_REL, 16'h0240, 16'h0200, 0, 1);
    @(posedge i_clk) seq <= 1'b1;
    @(posedge i_clk) seq <= 1'b0;
    @(negedge i_clk);
    chk(16'(fch.req), 16'h0001);
    chk(fch.addr, 16'h0200 + HIT_RESUME + WORD_STEP);
    repeat (12) @(posedge i_clk);
  endtask
  // Absolute jump as target of a bit-test jump, transfer after it
  task automatic sc_abs_target;
    run(BJC_CLS_BIT, 16'h0320, 16'h0340, 0, 0);
    run(BJC_CLS_ABS, 16'h0340, 16'h0300, 1, 0);
    run(BJC_CLS_ABS, 16'h0340, 16'h0300, 0, 1);
  endtask
  // A jump of another class leaves the entry alone
  task automatic sc_other_class;
    run(BJC_CLS_OTHER, 16'h0360, 16'h0500, 0, 2);
    run(BJC_CLS_ABS, 16'h0340, 16'h0300, 0, 1);
  endtask
  // A segment change kills the entry
  task automatic sc_seg_kill;
    run(BJC_CLS_SEG, 16'h0400, 16'h0600, 0, 2);
    run(BJC_CLS_ABS, 16'h0340, 16'h0300, 0, 0);
  endtask
  // An interrupt kills the entry, before the jump and in mid-fill
  task automatic sc_irq_kill;
    @(posedge i_clk) irq <= 1'b1;
    run(BJC_CLS_ABS, 16'h0340, 16'h0300, 0, 0);
    @(posedge i_clk) jmp <= '{1'b1, BJC_CLS_REL, 16'h0440, 16'h0400};
    @(posedge i_clk) jmp <= '0;
    irq <= 1'b1;
    @(posedge i_clk) irq <= 1'b0;
    repeat (20) @(posedge i_clk);
    run(BJC_CLS_REL, 16'h0440, 16'h0400, 0, 0);
  endtask
  initial
  begin
    repeat (20) @(posedge i_clk);
    rst <= 1'b0;
    sc_fill_hit();
    sc_rel_target();
    sc_abs_target();
    sc_other_class();
    sc_seg_kill();
    sc_irq_kill();
    end_sim();
  end
endmodule
bind bjc_jump_cache bjc_jump_cache_sva u_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_jump(i_jump),
  .i_irq_taken(i_irq_taken), .o_fetch(o_fetch), .o_word_valid(o_word_valid), .o_from_cache(o_from_cache),
  .o_hit(o_hit));
`default_nettype wire

// ### inc/bjc_pkg.sv
// Package for the branch target jump cache: rule overview, constants and carriers
// Overview of operation
// [RULE_01] Only taken relative, absolute or bit-test jumps load the jump cache.
// [RULE_02] On a hit, supply cached words at target A and A+2 without refetching.
// [RULE_03] Hit only if no cache-loading jump, segment change or interrupt intervened.
// [RULE_04] After both cached words, fetch resumes at A+4, even after event transfer.
// [RULE_05] Relative jump is one word long, also as direct target of a jump.
// [RULE_06] Absolute jump reached from a cache-loading jump also resumes at A+4.
// [RULE_07] On a miss, fetch target normally and store its first two words. A jump that arrives during a hit or a fill is neither fetched nor stored.
package bjc_pkg;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned DATA_W        = 16;
  localparam logic [15:0] WORD_STEP     = 16'h0002;
  localparam logic [15:0] HIT_RESUME    = 16'h0004;
  localparam logic [15:0] RST_ADDR      = 16'h0000;
  localparam logic [15:0] RST_WORD      = 16'h0000;

  typedef enum logic [2:0]
  {
    BJC_CLS_OTHER,
    BJC_CLS_REL,
    BJC_CLS_ABS,
    BJC_CLS_BIT,
    BJC_CLS_SEG
  } bjc_cls_e;

  // Branch report from the execute stage
  typedef struct packed
  {
    logic        taken;
    bjc_cls_e    cls;
    logic [15:0] pc;
    logic [15:0] target;
  } bjc_jump_s;

  // Fetch request towards program memory
  typedef struct packed
  {
    logic        req;
    logic [15:0] addr;
  } bjc_fetch_s;
endpackage

// ### verilog/bjc_jump_cache.sv
// Jump cache between instruction fetch and program memory
`timescale 1ns/1ps
`default_nettype none
module bjc_jump_cache
  import bjc_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Execute stage events
  input  var  bjc_jump_s   i_jump,
  input  wire logic        i_irq_taken,
  input  wire logic        i_evt_xfer,
  // Fetch unit side
  input  wire logic        i_seq_req,
  output bjc_fetch_s       o_fetch,
  // Program memory return
  input  wire logic        i_mem_valid,
  input  wire logic [15:0] i_mem_data,
  // Words to the decoder
  output logic             o_word_valid,
  output logic [15:0]      o_word,
  output logic             o_from_cache,
  output logic             o_hit
);
  typedef enum logic [1:0]
  {
    BJC_ST_RUN,
    BJC_ST_HIT0,
    BJC_ST_HIT1,
    BJC_ST_FILL
  } bjc_state_e;

  bjc_state_e  state;
  logic        valid;
  logic        fill_live;
  logic [15:0] tag_pc;
  logic [15:0] tag_target;
  logic [15:0] fetch_addr;
  logic        fill_idx;
  logic        rd_idx;
  logic [15:0] rd_word;
  logic        loads;
  logic        is_hit;
  logic        store_wr;

  // Only these classes load the cache [RULE_01]
  assign loads = i_jump.taken && (i_jump.cls == BJC_CLS_REL || i_jump.cls == BJC_CLS_ABS
                                  || i_jump.cls == BJC_CLS_BIT);

  // Tag holds the jump's own address; a one-word relative jump that is the
  // target of another jump is matched by its own pc, not by its predecessor [RULE_05]
  assign is_hit = loads && valid && (tag_pc == i_jump.pc) && (tag_target == i_jump.target)
                  && (state == BJC_ST_RUN);

  assign store_wr = (state == BJC_ST_FILL) && i_mem_valid;

  bjc_word_store #(
    .WIDTH (DATA_W)
  ) u_store (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr      (store_wr),
    .i_wr_idx  (fill_idx),
    .i_wr_data (i_mem_data),
    .i_rd_idx  (rd_idx),
    .o_rd_data (rd_word)
  );

  // Validity and tag of the single entry
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      valid      <= 1'b0;
      tag_pc     <= RST_ADDR;
      tag_target <= RST_ADDR;
    end
    else if (i_irq_taken || (i_jump.taken && i_jump.cls == BJC_CLS_SEG))
    begin
      valid <= 1'b0; // [RULE_03]
    end
    else if (loads && !is_hit)
    begin
      // Another cache-loading jump replaces the entry, so the old one cannot hit [RULE_03]
      valid <= 1'b0;
      // Jumps refused while busy must not retag the words being fetched
      if (state == BJC_ST_RUN)
      begin
        tag_pc     <= i_jump.pc;
        tag_target <= i_jump.target;
      end
    end
    else if (store_wr && fill_idx)
    begin
      valid <= fill_live; // [RULE_07]
    end
  end

  // A fill overtaken by an interrupt, a segment change or another loading jump
  // must never turn the entry valid, or a stale pair could hit later [RULE_03]
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      fill_live <= 1'b0;
    end
    else if (i_irq_taken || (i_jump.taken && i_jump.cls == BJC_CLS_SEG))
    begin
      fill_live <= 1'b0;
    end
    else if (loads && !is_hit)
    begin
      fill_live <= (state == BJC_ST_RUN);
    end
  end

  // Fetch sequencing; resume address is computed from the target only, so an
  // event transfer between the jump and its target cannot skew it [RULE_04] [RULE_06]
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state      <= BJC_ST_RUN;
      fetch_addr <= RST_ADDR;
      fill_idx   <= 1'b0;
      rd_idx     <= 1'b0;
      o_fetch    <= '0;
    end
    else
    begin
      case (state)
        BJC_ST_RUN:
        begin
          if (is_hit)
          begin
            state      <= BJC_ST_HIT0; // [RULE_02]
            rd_idx     <= 1'b1;
            fetch_addr <= i_jump.target + HIT_RESUME; // [RULE_04]
            o_fetch    <= '0;
          end
          else if (i_jump.taken)
          begin
            state      <= (loads && !(i_irq_taken)) ? BJC_ST_FILL : BJC_ST_RUN;
            fill_idx   <= 1'b0;
            fetch_addr <= i_jump.target + WORD_STEP;
            o_fetch    <= '{req: 1'b1, addr: i_jump.target}; // [RULE_07]
          end
          else if (i_seq_req)
          begin
            fetch_addr <= fetch_addr + WORD_STEP;
            o_fetch    <= '{req: 1'b1, addr: fetch_addr};
          end
          else
          begin
            o_fetch.req <= 1'b0;
          end
        end
        BJC_ST_HIT0:
        begin
          state  <= BJC_ST_HIT1;
          rd_idx <= 1'b0;
        end
        BJC_ST_HIT1:
        begin
          // Second cached word leaves now; memory resumes past both [RULE_04]
          state      <= BJC_ST_RUN;
          fetch_addr <= fetch_addr + WORD_STEP;
          o_fetch    <= '{req: 1'b1, addr: fetch_addr};
        end
        BJC_ST_FILL:
        begin
          o_fetch.req <= 1'b0;
          if (i_mem_valid)
          begin
            if (fill_idx)
            begin
              state <= BJC_ST_RUN;
            end
            else
            begin
              fill_idx   <= 1'b1;
              fetch_addr <= fetch_addr + WORD_STEP;
              o_fetch    <= '{req: 1'b1, addr: fetch_addr};
            end
          end
        end
        default:
          state <= BJC_ST_RUN;
      endcase
    end
  end

  // Word delivery: cached words on a hit, memory data otherwise [RULE_02]
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_word_valid <= 1'b0;
      o_word       <= RST_WORD;
      o_from_cache <= 1'b0;
      o_hit        <= 1'b0;
    end
    else
    begin
      o_hit <= is_hit;
      if (state == BJC_ST_HIT0 || state == BJC_ST_HIT1)
      begin
        o_word_valid <= 1'b1;
        o_word       <= rd_word;
        o_from_cache <= 1'b1;
      end
      else
      begin
        o_word_valid <= i_mem_valid;
        o_word       <= i_mem_data;
        o_from_cache <= 1'b0;
      end
    end
  end

  // Event transfers steal bus slots only; fetch state is left untouched
  logic unused_evt;
  assign unused_evt = i_evt_xfer;
endmodule
`default_nettype wire

// ### verilog/bjc_word_store.sv
// Two-entry word store holding the instruction words at the jump target
`timescale 1ns/1ps
`default_nettype none
module bjc_word_store
  import bjc_pkg::*;
#(
  parameter int unsigned WIDTH = 16
)
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // Write side
  input  wire logic             i_wr,
  input  wire logic             i_wr_idx,
  input  wire logic [WIDTH-1:0] i_wr_data,
  // Read side
  input  wire logic             i_rd_idx,
  output logic      [WIDTH-1:0] o_rd_data
);
  logic [WIDTH-1:0] mem [2];

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      mem[0] <= WIDTH'(RST_WORD);
      mem[1] <= WIDTH'(RST_WORD);
    end
    else if (i_wr)
    begin
      mem[i_wr_idx] <= i_wr_data;
    end
  end

  // Registered read, so the word is ready the cycle after selection
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_rd_data <= WIDTH'(RST_WORD);
    else
      o_rd_data <= mem[i_rd_idx];
  end
endmodule
`default_nettype wire
